// File: design/qx_arbiter.sv
// qx_arbiter: priority arbiter of one crossbar unit; highest level
// wins, equal levels rotate.
// assumes: requests held stable until taken; same clock as caller.
`timescale 1ns/1ps
module qx_arbiter #(
	parameter int N  = 3,
	parameter int LW = `QX_LVL_W,
	localparam int IW = $clog2(N)
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_b,
	// requests
	input  wire logic [N-1:0]         req,
	input  wire logic [N-1:0][LW-1:0] level,
	input  wire logic               take,
	// winner
	output logic                    any,
	output logic [IW-1:0]           idx
);

	logic [IW-1:0] ptr_q;
	logic [LW-1:0] top;
	logic          found;

	// ==========================================================
	// highest level, then rotation among the tied
	always_comb begin
		top   = '0;
		found = 1'b0;
		idx   = '0;
		any   = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (req[i] && (!found || level[i] > top)) begin
				top   = level[i];
				found = 1'b1;
			end
		end
		for (int k = 1; k <= N; k++) begin
			if (!any && req[(int'(ptr_q) + k) % N] &&
			    level[(int'(ptr_q) + k) % N] == top) begin
				idx = IW'((int'(ptr_q) + k) % N);
				any = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ptr_q <= '0;
		else if (take)
			ptr_q <= idx;
	end

endmodule

// File: design/qx_cfg.svh
// qx_cfg.svh: address map, field positions and timing counts of the
// crossbar and its system SRAM controller.
// assumes: included by bare name; definitions only.
`ifndef QX_CFG_SVH
`define QX_CFG_SVH

// ==========================================================
// address decode
`define QX_REGION_MASK 32'hFF000000
`define QX_LOCAL_BASE  32'h28000000
`define QX_SRAM_BASE   32'h20000000

// ==========================================================
// widths and banking
`define QX_LVL_W       4
`define QX_CNT_W       4
`define QX_BANKS       8
`define QX_BANK_LSB    3
`define QX_ECC_W       7

// ==========================================================
// timing in fabric cycles
`define QX_BASE_CYC    2'h1
`define QX_ECC_EXTRA   2'h2
`define QX_RMW_CYC     2'h3
`define QX_ASYNC_EXTRA 2'h2

`endif

// File: design/qx_crossbar.sv
// qx_crossbar: two lower crossbar units feeding an upper unit that
// routes to core-local SRAM, system SRAM and a DRAM bridge.
// assumes: masters are clocked in fixed ratio to the fabric clock and
// hold a request until ready; slaves answer on the fabric clock.
`timescale 1ns/1ps
module qx_crossbar #(
	parameter int NL    = 3,
	parameter int LW    = `QX_LVL_W,
	parameter int CW    = `QX_CNT_W,
	parameter int DEPTH = 64,
	localparam int NM   = 2 * NL,
	localparam int IDW  = $clog2(NM + 1),
	localparam int LIW  = $clog2(NL)
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// masters of the two lower units
	input  wire logic [NM-1:0]        mValid,
	input  qx_pkg::qx_req_t           mPkt [NM],
	input  wire logic [NM-1:0][LW-1:0] mLevel,
	output logic [NM-1:0]             mReady,
	output logic                      rspValid,
	output logic [IDW-1:0]            rspId,
	output qx_pkg::qx_rsp_t           rspData,
	// fast copy engine
	input  wire logic                 fcValid,
	input  qx_pkg::qx_req_t           fcPkt,
	input  wire logic [LW-1:0]        fcLevel,
	output logic                      fcReady,
	output logic                      fcRspValid,
	output qx_pkg::qx_rsp_t           fcRsp,
	// core ports of the system SRAM
	input  wire logic                 coreRdValid,
	input  qx_pkg::qx_req_t           coreRdPkt,
	input  wire logic                 coreWrValid,
	input  qx_pkg::qx_req_t           coreWrPkt,
	output logic                      coreRdDone,
	output logic                      coreWrDone,
	output qx_pkg::qx_rsp_t           coreRdRsp,
	// system SRAM configuration
	input  wire logic [`QX_BANKS-1:0] eccEnable,
	input  wire logic [CW-1:0]        coreRdCnt,
	input  wire logic [CW-1:0]        coreWrCnt,
	input  wire logic [CW-1:0]        dmaRdCnt,
	input  wire logic [CW-1:0]        dmaWrCnt,
	// core-local SRAM, dma_port_one
	output logic                      p1Valid,
	output qx_pkg::qx_req_t           p1Pkt,
	input  wire logic                 p1Ready,
	input  wire logic                 p1RspValid,
	input  qx_pkg::qx_rsp_t           p1Rsp,
	// core-local SRAM, dma_port_two
	output logic                      p2Valid,
	output qx_pkg::qx_req_t           p2Pkt,
	input  wire logic                 p2Ready,
	input  wire logic                 p2RspValid,
	input  qx_pkg::qx_rsp_t           p2Rsp,
	// dram bridge
	input  wire logic                 bridgeSync,
	output logic                      drValid,
	output qx_pkg::qx_req_t           drPkt,
	input  wire logic                 drReady,
	input  wire logic                 drRspValid,
	input  qx_pkg::qx_rsp_t           drRsp
);

	localparam logic [IDW-1:0] FC_ID = IDW'(NM);

	function automatic qx_pkg::qx_slave_t slaveOf(input logic [31:0] a);
		// local SRAM is reached only through the offset window
		if ((a & `QX_REGION_MASK) == `QX_LOCAL_BASE)
			return qx_pkg::QX_SL_LOCAL;
		if ((a & `QX_REGION_MASK) == `QX_SRAM_BASE)
			return qx_pkg::QX_SL_SRAM;
		return qx_pkg::QX_SL_DRAM;
	endfunction

	// ==========================================================
	// master-facing capture: one register per fixed master port
	logic [NM-1:0]          holdV_q;
	logic [NM-1:0]          holdV_d;
	logic [NM-1:0]          holdTake;
	qx_pkg::qx_req_t        holdPkt_q [NM];
	logic [NM-1:0][LW-1:0]  holdLvl_q;

	// masters run edge-aligned at fixed ratios, so one capture
	// register is the whole crossing
	assign holdV_d = (holdV_q & ~holdTake) | (mValid & mReady);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			holdV_q   <= '0;
			mReady    <= '0;
			holdLvl_q <= '0;
			holdPkt_q <= '{default: '0};
		end else begin
			holdV_q <= holdV_d;
			mReady  <= ~holdV_d;
			for (int i = 0; i < NM; i++) begin
				if (mValid[i] && mReady[i]) begin
					holdPkt_q[i] <= mPkt[i];
					holdLvl_q[i] <= mLevel[i];
				end
			end
		end
	end

	// ==========================================================
	// lower crossbar units
	logic [1:0]             lwV_q;
	logic [1:0]             lwTake;
	logic [1:0]             upTakeLw;
	logic [1:0]             lAny;
	logic [1:0][LIW-1:0]    lIdx;
	qx_pkg::qx_req_t        lwPkt_q [2];
	logic [1:0][LW-1:0]     lwLvl_q;
	logic [1:0][IDW-1:0]    lwId_q;

	for (genvar u = 0; u < 2; u++) begin : g_low
		qx_arbiter #(.N(NL), .LW(LW)) uArb (
			.clk   (clk),
			.rst_b (rst_b),
			.req   (holdV_q[u*NL +: NL]),
			.level (holdLvl_q[u*NL +: NL]),
			.take  (lwTake[u]),
			.any   (lAny[u]),
			.idx   (lIdx[u])
		);
		assign lwTake[u] = lAny[u] && !lwV_q[u];
		for (genvar k = 0; k < NL; k++) begin : g_tk
			assign holdTake[u*NL+k] = lwTake[u] && lIdx[u] == LIW'(k);
		end
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				lwV_q[u]   <= 1'b0;
				lwPkt_q[u] <= '0;
				lwLvl_q[u] <= '0;
				lwId_q[u]  <= '0;
			end else if (lwTake[u]) begin
				lwV_q[u]   <= 1'b1;
				lwPkt_q[u] <= holdPkt_q[u*NL + int'(lIdx[u])];
				lwLvl_q[u] <= holdLvl_q[u*NL + int'(lIdx[u])];
				lwId_q[u]  <= IDW'(u*NL + int'(lIdx[u]));
			end else if (upTakeLw[u]) begin
				lwV_q[u]   <= 1'b0;
			end
		end
	end

	// ==========================================================
	// fast copy capture and its dedicated dma_port_two path
	logic                   fcV_q;
	logic                   fcV_d;
	qx_pkg::qx_req_t        fcPkt_q;
	logic [LW-1:0]          fcLvl_q;
	logic                   fcLocal;
	logic                   p2Busy_q;
	logic                   p2Start;
	logic                   upTakeFc;

	assign fcLocal = fcV_q && slaveOf(fcPkt_q.addr) == qx_pkg::QX_SL_LOCAL;
	assign p2Start = fcLocal && !p2Busy_q;
	assign fcV_d   = (fcV_q && !(upTakeFc || p2Start)) ||
	                 (fcValid && fcReady);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fcV_q   <= 1'b0;
			fcReady <= 1'b0;
			fcPkt_q <= '0;
			fcLvl_q <= '0;
		end else begin
			fcV_q   <= fcV_d;
			fcReady <= !fcV_d;
			if (fcValid && fcReady) begin
				fcPkt_q <= fcPkt;
				fcLvl_q <= fcLevel;
			end
		end
	end

	// port two runs beside the crossbar path, so two banks of the
	// local SRAM can be busy at once
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			p2Busy_q <= 1'b0;
			p2Valid  <= 1'b0;
			p2Pkt    <= '0;
		end else begin
			if (p2Start) begin
				p2Busy_q <= 1'b1;
				p2Valid  <= 1'b1;
				p2Pkt    <= fcPkt_q;
			end else begin
				if (p2Valid && p2Ready)
					p2Valid <= 1'b0;
				if (p2Busy_q && !p2Valid && p2RspValid)
					p2Busy_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// upper crossbar unit: only lower winners and fast copy compete
	qx_pkg::qx_state_t      state_q;
	qx_pkg::qx_req_t        cur_q;
	qx_pkg::qx_slave_t      curSl_q;
	logic [IDW-1:0]         curId_q;
	logic [1:0]             asyncCnt_q;
	logic                   uAny;
	logic [1:0]             uIdx;
	logic                   upTake;
	qx_pkg::qx_req_t        upPkt;
	logic [IDW-1:0]         upId;
	logic                   sramReq;
	logic                   fin;
	qx_pkg::qx_rsp_t        finRsp;
	logic [3:0]             chReq;
	logic [3:0]             chDone;
	qx_pkg::qx_req_t        chPkt [4];
	qx_pkg::qx_rsp_t        chRsp [4];

	qx_arbiter #(.N(3), .LW(LW)) uTop (
		.clk   (clk),
		.rst_b (rst_b),
		.req   ({fcV_q && !fcLocal, lwV_q}),
		.level ({fcLvl_q, lwLvl_q}),
		.take  (upTake),
		.any   (uAny),
		.idx   (uIdx)
	);

	assign upTake   = uAny && state_q == qx_pkg::QX_IDLE;
	assign upTakeLw = {upTake && uIdx == 2'h1, upTake && uIdx == 2'h0};
	assign upTakeFc = upTake && uIdx == 2'h2;
	assign upPkt    = uIdx == 2'h2 ? fcPkt_q : lwPkt_q[uIdx[0]];
	assign upId     = uIdx == 2'h2 ? FC_ID : lwId_q[uIdx[0]];
	assign sramReq  = state_q == qx_pkg::QX_ISSUE &&
	                  curSl_q == qx_pkg::QX_SL_SRAM;
	assign fin      = (sramReq && (chDone[2] || chDone[3])) ||
	                  (state_q == qx_pkg::QX_WAIT &&
	                   (curSl_q == qx_pkg::QX_SL_LOCAL ?
	                    p1RspValid : drRspValid));
	assign finRsp   = curSl_q == qx_pkg::QX_SL_SRAM ?
	                  (cur_q.wr ? chRsp[3] : chRsp[2]) :
	                  curSl_q == qx_pkg::QX_SL_LOCAL ? p1Rsp : drRsp;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= qx_pkg::QX_IDLE;
			cur_q      <= '0;
			curSl_q    <= qx_pkg::QX_SL_LOCAL;
			curId_q    <= '0;
			asyncCnt_q <= '0;
			p1Valid    <= 1'b0;
			drValid    <= 1'b0;
		end else begin
			unique case (state_q)
			qx_pkg::QX_IDLE: if (upTake) begin
				state_q <= qx_pkg::QX_ISSUE;
				cur_q   <= upPkt;
				curSl_q <= slaveOf(upPkt.addr);
				curId_q <= upId;
				// ordinary dma to local SRAM always takes port one
				p1Valid <= slaveOf(upPkt.addr) == qx_pkg::QX_SL_LOCAL;
				// async bridge pays its synchroniser delay up front
				asyncCnt_q <= bridgeSync ? 2'h0 : `QX_ASYNC_EXTRA;
			end
			qx_pkg::QX_ISSUE: begin
				if (p1Valid && p1Ready) begin
					p1Valid <= 1'b0;
					state_q <= qx_pkg::QX_WAIT;
				end else if (curSl_q == qx_pkg::QX_SL_DRAM) begin
					if (asyncCnt_q != 2'h0)
						asyncCnt_q <= asyncCnt_q - 2'h1;
					else if (drValid && drReady) begin
						drValid <= 1'b0;
						state_q <= qx_pkg::QX_WAIT;
					end else
						drValid <= 1'b1;
				end else if (fin)
					state_q <= qx_pkg::QX_IDLE;
			end
			qx_pkg::QX_WAIT: if (fin)
				state_q <= qx_pkg::QX_IDLE;
			endcase
		end
	end

	assign p1Pkt = cur_q;
	assign drPkt = cur_q;

	// ==========================================================
	// answers back to the masters
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rspValid   <= 1'b0;
			rspId      <= '0;
			rspData    <= '0;
			fcRspValid <= 1'b0;
			fcRsp      <= '0;
		end else begin
			rspValid   <= fin && curId_q != FC_ID;
			fcRspValid <= (fin && curId_q == FC_ID) ||
			              (p2Busy_q && !p2Valid && p2RspValid);
			if (fin) begin
				rspId   <= curId_q;
				rspData <= finRsp;
			end
			if (fin && curId_q == FC_ID)
				fcRsp <= finRsp;
			else if (p2Busy_q && !p2Valid && p2RspValid)
				fcRsp <= p2Rsp;
		end
	end

	// ==========================================================
	// system SRAM controller
	assign chReq = {sramReq && cur_q.wr, sramReq && !cur_q.wr,
	                coreWrValid, coreRdValid};
	assign chPkt = '{coreRdPkt, coreWrPkt, cur_q, cur_q};

	qx_sram_ctl #(.DEPTH(DEPTH), .CW(CW)) uSram (
		.clk       (clk),
		.rst_b     (rst_b),
		.chReq     (chReq),
		.chPkt     (chPkt),
		.dmaWide   (curId_q == FC_ID),
		.chDone    (chDone),
		.chRsp     (chRsp),
		.eccEnable (eccEnable),
		.coreRdCnt (coreRdCnt),
		.coreWrCnt (coreWrCnt),
		.dmaRdCnt  (dmaRdCnt),
		.dmaWrCnt  (dmaWrCnt)
	);

	assign coreRdDone = chDone[0];
	assign coreWrDone = chDone[1];
	assign coreRdRsp  = chRsp[0];

endmodule

// File: design/qx_pkg.sv
// qx_pkg: types shared by the crossbar, the SRAM controller and the
// testbench.
// assumes: nothing beyond the configuration header.
`include "qx_cfg.svh"
package qx_pkg;

	// ==========================================================
	// transfer sizes
	typedef enum logic [1:0] {
		QX_SZ8,
		QX_SZ16,
		QX_SZ32,
		QX_SZ64
	} qx_size_t;

	// ==========================================================
	// request and answer carriers
	typedef struct packed {
		logic [31:0] addr;
		logic        wr;
		qx_size_t    size;
		logic [63:0] wdata;
	} qx_req_t;

	typedef struct packed {
		logic [63:0] rdata;
		logic        err;
	} qx_rsp_t;

	// ==========================================================
	// slave ports and transaction states
	typedef enum logic [1:0] {
		QX_SL_LOCAL,
		QX_SL_SRAM,
		QX_SL_DRAM
	} qx_slave_t;

	typedef enum logic [1:0] {
		QX_IDLE,
		QX_ISSUE,
		QX_WAIT
	} qx_state_t;

endpackage

// File: design/qx_sram_ctl.sv
// qx_sram_ctl: system SRAM controller; core and DMA ports, each with
// its own read and write channel, eight ECC banks.
// assumes: a channel holds its request until its done pulse.
`timescale 1ns/1ps
module qx_sram_ctl #(
	parameter int DEPTH = 64,
	parameter int CW    = `QX_CNT_W,
	localparam int RW   = $clog2(DEPTH),
	localparam int BW   = $clog2(`QX_BANKS)
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_b,
	// channels: 0 core rd, 1 core wr, 2 dma rd, 3 dma wr
	input  wire logic [3:0]         chReq,
	input  qx_pkg::qx_req_t         chPkt [4],
	input  wire logic               dmaWide,
	output logic [3:0]              chDone,
	output qx_pkg::qx_rsp_t         chRsp [4],
	// configuration
	input  wire logic [`QX_BANKS-1:0] eccEnable,
	input  wire logic [CW-1:0]      coreRdCnt,
	input  wire logic [CW-1:0]      coreWrCnt,
	input  wire logic [CW-1:0]      dmaRdCnt,
	input  wire logic [CW-1:0]      dmaWrCnt
);

	logic [63:0]              mem [`QX_BANKS*DEPTH];
	logic [2*`QX_ECC_W-1:0]   chk [`QX_BANKS*DEPTH];
	logic [3:0]               busy_q;
	logic [3:0][1:0]          cnt_q;
	logic [1:0]               owner_q;
	logic [1:0][CW-1:0]       used_q;
	logic [3:0][BW+RW-1:0]    idx;
	logic [3:0][BW-1:0]       bank;
	logic [3:0][1:0]          lat;
	logic [3:0][63:0]         mask;
	logic [3:0][63:0]         word;
	logic [3:0]               elig;
	logic [3:0]               grant;
	logic [1:0]               conf;
	logic [1:0][CW-1:0]       lim;

	function automatic logic [`QX_ECC_W-1:0] ecc32(input logic [31:0] d);
		logic [`QX_ECC_W-1:0] e;
		e = '0;
		for (int j = 0; j < 32; j++)
			for (int i = 0; i < `QX_ECC_W - 1; i++)
				if ((((j + 1) >> i) & 1) != 0)
					e[i] = e[i] ^ d[j];
		e[`QX_ECC_W-1] = ^d;
		return e;
	endfunction

	function automatic logic [CW-1:0] limOf(input logic [CW-1:0] c);
		return (c == '0) ? CW'(1) : c;
	endfunction

	// ==========================================================
	// per-channel decode
	for (genvar c = 0; c < 4; c++) begin : g_ch
		logic narrow;
		logic [5:0] off;
		assign bank[c]   = chPkt[c].addr[`QX_BANK_LSB +: BW];
		assign idx[c]    = {chPkt[c].addr[`QX_BANK_LSB+BW +: RW], bank[c]};
		assign off       = {chPkt[c].addr[2:0], 3'h0};
		assign narrow    = chPkt[c].size inside {qx_pkg::QX_SZ8,
		                                         qx_pkg::QX_SZ16};
		// narrow ecc write is read-modify-write, narrow read pays ecc
		assign lat[c]    = !(narrow && eccEnable[bank[c]]) ?
		                   `QX_BASE_CYC :
		                   (c % 2 == 1) ? `QX_RMW_CYC :
		                   `QX_BASE_CYC + `QX_ECC_EXTRA;
		// every access becomes one 64-bit word with a lane mask
		assign mask[c]   = (chPkt[c].size == qx_pkg::QX_SZ8  ? 64'hFF :
		                    chPkt[c].size == qx_pkg::QX_SZ16 ? 64'hFFFF :
		                    chPkt[c].size == qx_pkg::QX_SZ32 ?
		                    64'hFFFFFFFF : {64{1'b1}}) << off;
		assign word[c]   = mem[idx[c]] >> off;
		assign elig[c]   = chReq[c] && !busy_q[c] && !chDone[c] &&
		                   !(busy_q[c^2] && bank[c^2] == bank[c]);
	end

	// ==========================================================
	// core/dma contention per direction, counted hand-over
	for (genvar d = 0; d < 2; d++) begin : g_dir
		assign conf[d] = elig[d] && elig[d+2] && bank[d] == bank[d+2];
		assign grant[d] = elig[d] && (!conf[d] || !owner_q[d]);
		assign grant[d+2] = elig[d+2] && (!conf[d] || owner_q[d]);
	end
	assign lim[0] = owner_q[0] ? limOf(dmaRdCnt) : limOf(coreRdCnt);
	assign lim[1] = owner_q[1] ? limOf(dmaWrCnt) : limOf(coreWrCnt);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			owner_q <= '0;
			used_q  <= '0;
		end else begin
			for (int d = 0; d < 2; d++) begin
				if (conf[d] && used_q[d] + CW'(1) >= lim[d]) begin
					owner_q[d] <= !owner_q[d];
					used_q[d]  <= '0;
				end else if (conf[d]) begin
					used_q[d]  <= used_q[d] + CW'(1);
				end
			end
		end
	end

	// ==========================================================
	// channel timing; read and write channels run in parallel
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_q <= '0;
			cnt_q  <= '0;
			chDone <= '0;
			chRsp  <= '{default: '0};
		end else begin
			for (int c = 0; c < 4; c++) begin
				chDone[c] <= 1'b0;
				if (grant[c]) begin
					busy_q[c] <= 1'b1;
					cnt_q[c]  <= lat[c];
				end else if (busy_q[c] && cnt_q[c] == 2'h1) begin
					busy_q[c] <= 1'b0;
					chDone[c] <= 1'b1;
					chRsp[c].rdata <= (c >= 2 && !dmaWide) ?
						{32'h0, word[c][31:0]} : word[c];
					chRsp[c].err <= eccEnable[bank[c]] &&
						chk[idx[c]] != {ecc32(mem[idx[c]][63:32]),
						                ecc32(mem[idx[c]][31:0])};
				end else if (busy_q[c]) begin
					cnt_q[c] <= cnt_q[c] - 2'h1;
				end
			end
		end
	end

	// ==========================================================
	// storage; address order never changes the cycle count
	always_ff @(posedge clk) begin
		for (int c = 1; c < 4; c += 2) begin
			if (busy_q[c] && cnt_q[c] == 2'h1) begin
				logic [63:0] m;
				m = (mem[idx[c]] & ~mask[c]) |
				    ((chPkt[c].wdata << {chPkt[c].addr[2:0], 3'h0})
				     & mask[c]);
				mem[idx[c]] <= m;
				chk[idx[c]] <= {ecc32(m[63:32]), ecc32(m[31:0])};
			end
		end
	end

endmodule

// File: tb/qx_crossbar_asserts.sv
// qx_crossbar_asserts: port-level checks of the crossbar.
// assumes: bound into qx_crossbar; slaves answer after ready.
`timescale 1ns/1ps
module qx_crossbar_asserts #(
	parameter int NL = 3
) (
	// clock and reset
	input wire logic            clk,
	input wire logic            rst_b,
	// masters and core
	input wire logic [2*NL-1:0] mValid,
	input wire logic [2*NL-1:0] mReady,
	input wire logic            rspValid,
	input wire logic            fcValid,
	input qx_pkg::qx_req_t      fcPkt,
	input wire logic            fcReady,
	input wire logic            coreRdDone,
	// slaves
	input wire logic            p1Valid,
	input qx_pkg::qx_req_t      p1Pkt,
	input wire logic            p1Ready,
	input wire logic            p1RspValid,
	input wire logic            p2Valid,
	input qx_pkg::qx_req_t      p2Pkt,
	input wire logic            drValid,
	input qx_pkg::qx_req_t      drPkt,
	input wire logic            drReady
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// port relations
	property p_take; mValid[0] && mReady[0] |=> !mReady[0]; endproperty
	a_take: assert property (p_take)
		else $error("ready kept after take");
	property p_p1hold; p1Valid && !p1Ready |=> p1Valid && $stable(p1Pkt);
	endproperty
	a_p1hold: assert property (p_p1hold)
		else $error("port one request moved");
	property p_p1map; p1Valid |-> p1Pkt.addr[31:24] == 8'h28; endproperty
	a_p1map: assert property (p_p1map)
		else $error("port one off region");
	property p_p2map; p2Valid |-> p2Pkt.addr[31:24] == 8'h28; endproperty
	a_p2map: assert property (p_p2map)
		else $error("port two off region");
	property p_fcpath;
		fcValid && fcReady && fcPkt.addr[31:24] == 8'h28 |-> ##[1:4] p2Valid;
	endproperty
	a_fcpath: assert property (p_fcpath)
		else $error("fast copy missed port two");
	property p_answer; p1RspValid |=> rspValid; endproperty
	a_answer: assert property (p_answer)
		else $error("answer not passed back");
	property p_drhold; drValid && !drReady |=> drValid && $stable(drPkt);
	endproperty
	a_drhold: assert property (p_drhold)
		else $error("bridge request moved");
	property p_drmap;
		drValid |-> !(drPkt.addr[31:24] inside {8'h28, 8'h20});
	endproperty
	a_drmap: assert property (p_drmap)
		else $error("bridge got local access");
	property p_done; coreRdDone |=> !coreRdDone; endproperty
	a_done: assert property (p_done)
		else $error("read done too long");
	c_all: cover property (mValid == '1);
	c_fc: cover property (p2Valid);
	c_dr: cover property (drValid && drReady);
endmodule

// File: tb/qx_crossbar_tb.sv
// qx_crossbar_tb: directed sequences on masters, fast copy and core.
// assumes: slave models on both local ports and the DRAM bridge.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("mismatch at %0t got %0h exp %0h", $time, a, b); end end
module qx_crossbar_tb;
	logic clk = 1'b0, rst_b = 1'b0;
	logic [5:0] mValid = '0, mReady, hs;
	logic [5:0][3:0] mLevel = '0;
	qx_pkg::qx_req_t mPkt [6], fcPkt = '0, coreRdPkt = '0, coreWrPkt = '0;
	qx_pkg::qx_req_t p1Pkt, p2Pkt, drPkt;
	qx_pkg::qx_rsp_t rspData, fcRsp, coreRdRsp, p1Rsp, p2Rsp, drRsp;
	logic [2:0] rspId;
	logic rspValid, fcReady, fcRspValid, coreRdDone, coreWrDone;
	logic fcValid = 0, coreRdValid = 0, coreWrValid = 0, bridgeSync = 1;
	logic [3:0] fcLevel = 4'h3;
	logic [7:0] eccEnable = 8'h02, cnt = 8'h10;
	logic p1Valid, p1Ready, p1RspValid, p2Valid, p2Ready, p2RspValid;
	logic drValid, drReady, drRspValid;
	int miscompares = 0, n_checks = 0;
	qx_crossbar #(.NL(3)) dut (.clk, .rst_b, .mValid, .mPkt, .mLevel,
		.mReady, .rspValid, .rspId, .rspData, .fcValid, .fcPkt, .fcLevel,
		.fcReady, .fcRspValid, .fcRsp, .coreRdValid, .coreRdPkt,
		.coreWrValid, .coreWrPkt, .coreRdDone, .coreWrDone, .coreRdRsp,
		.eccEnable, .coreRdCnt(cnt[3:0]), .coreWrCnt(cnt[3:0]),
		.dmaRdCnt(cnt[7:4]), .dmaWrCnt(cnt[7:4]), .p1Valid, .p1Pkt,
		.p1Ready, .p1RspValid, .p1Rsp,
		.p2Valid, .p2Pkt, .p2Ready, .p2RspValid, .p2Rsp, .bridgeSync,
		.drValid, .drPkt, .drReady, .drRspValid, .drRsp);
	qx_slave_model #(.DLY(0)) slvP1 (.clk, .rst_b, .valid(p1Valid),
		.pkt(p1Pkt), .ready(p1Ready), .rspValid(p1RspValid), .rsp(p1Rsp));
	qx_slave_model #(.DLY(2)) slvP2 (.clk, .rst_b, .valid(p2Valid),
		.pkt(p2Pkt), .ready(p2Ready), .rspValid(p2RspValid), .rsp(p2Rsp));
	qx_slave_model #(.DLY(1)) slvDr (.clk, .rst_b, .valid(drValid),
		.pkt(drPkt), .ready(drReady), .rspValid(drRspValid), .rsp(drRsp));
	always #4 clk = ~clk;
	// ==========================================================
	// access tasks
	// masters drop valid only after the accepting edge
	always @(posedge clk) begin
		hs = mValid & mReady;
		#1 mValid = mValid & ~hs;
	end
	task automatic mreq(input int i, input logic [31:0] a);
		mPkt[i] = '{addr: a, wr: 1'b0, size: qx_pkg::QX_SZ32, wdata: '0};
		mValid[i] = 1'b1;
	endtask
	task automatic getrsp(output logic [2:0] id, output logic [63:0] d,
		output int n);
		n = 0;
		do begin @(posedge clk); #1; n++; end
		while (rspValid !== 1'b1 && n < 300);
		if (n >= 300) miscompares++;
		id = rspId;
		d = rspData.rdata;
	endtask
	task automatic fc(input logic [31:0] a, input logic w,
		input logic [63:0] wd, output logic [63:0] d);
		int n;
		logic t;
		fcPkt = '{addr: a, wr: w, size: qx_pkg::QX_SZ64, wdata: wd};
		fcValid = 1'b1;
		n = 0;
		do begin @(posedge clk); t = fcReady; #1; n++;
			if (t === 1'b1) fcValid = 1'b0; end
		while (fcRspValid !== 1'b1 && n < 300);
		if (n >= 300) miscompares++;
		d = fcRsp.rdata;
	endtask
	task automatic core(input logic w, input logic [31:0] a,
		input qx_pkg::qx_size_t s, input logic [63:0] wd,
		output int n, output logic [63:0] d);
		if (w) coreWrPkt = '{addr: a, wr: 1'b1, size: s, wdata: wd};
		else coreRdPkt = '{addr: a, wr: 1'b0, size: s, wdata: wd};
		coreWrValid = w;
		coreRdValid = !w;
		n = 0;
		do begin @(posedge clk); #1; n++; end
		while ((w ? coreWrDone : coreRdDone) !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		d = coreRdRsp.rdata;
		coreWrValid = 1'b0;
		coreRdValid = 1'b0;
		@(posedge clk); #1;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin #100000; miscompares++; test_done; end
	// ==========================================================
	// sequence
	initial begin
		int n0, n1, f;
		logic [2:0] id;
		logic [63:0] d;
		logic [5:0] seen;
		for (int i = 0; i < 6; i++) mPkt[i] = '0;
		repeat (5) @(posedge clk);
		`CHK(mReady, 6'h00)
		#1 rst_b = 1'b1;
		@(posedge clk); #1;
		`CHK(mReady, 6'h3F)
		mreq(0, 32'h28000040);
		getrsp(id, d, n0);
		`CHK(d, {32'h28000040, ~32'h28000040})
		mLevel = {4'h1, 4'hD, 4'hC, 4'h2, 4'h4, 4'h6};
		for (int i = 0; i < 6; i++) mreq(i, 32'h28000000 + 32'(i * 8));
		seen = '0;
		for (int i = 0; i < 6; i++) begin
			getrsp(id, d, n0);
			if (i == 0) `CHK(id, 3'h4)
			seen[id] = 1'b1;
		end
		`CHK(seen, 6'h3F)
		mLevel = {6{4'h5}};
		for (int i = 0; i < 3; i++) mreq(i, 32'h28000080);
		getrsp(id, d, n0);
		f = id;
		for (int k = 1; k < 3; k++) begin
			getrsp(id, d, n0);
			`CHK(id, 3'((f + k) % 3))
		end
		fc(32'h28000100, 1'b0, '0, d);
		`CHK(d, {32'h28000100, ~32'h28000100})
		fc(32'h20000010, 1'b1, 64'hA1B2C3D4E5F60718, d);
		fc(32'h20000010, 1'b0, '0, d);
		`CHK(d, 64'hA1B2C3D4E5F60718)
		mreq(1, 32'h20000010);
		getrsp(id, d, n0);
		`CHK(d, 64'h00000000E5F60718)
		core(1, 32'h20000008, qx_pkg::QX_SZ64, 64'h1122334455667788, n0, d);
		core(1, 32'h20000008, qx_pkg::QX_SZ8, 64'hAB, n1, d);
		`CHK(n1, n0 + 2)
		core(0, 32'h20000008, qx_pkg::QX_SZ64, '0, n1, d);
		`CHK(d, 64'h11223344556677AB)
		core(0, 32'h20000008, qx_pkg::QX_SZ8, '0, n1, d);
		`CHK(n1, n0 + 2)
		cnt = 8'h32;
		core(0, 32'h20000010, qx_pkg::QX_SZ8, '0, n1, d);
		`CHK(n1, n0)
		mreq(2, 32'h40000000);
		getrsp(id, d, n0);
		`CHK(d, {32'h40000000, ~32'h40000000})
		bridgeSync = 1'b0;
		mreq(2, 32'h40000000);
		getrsp(id, d, n1);
		`CHK(n1, n0 + 2)
		test_done;
	end
endmodule
bind qx_crossbar qx_crossbar_asserts #(.NL(NL)) chk (.clk, .rst_b,
	.mValid, .mReady, .rspValid, .fcValid, .fcPkt, .fcReady, .coreRdDone,
	.p1Valid, .p1Pkt, .p1Ready, .p1RspValid, .p2Valid, .p2Pkt, .drValid,
	.drPkt, .drReady);

// File: tb/qx_slave_model.sv
// qx_slave_model: behavioural slave for local SRAM ports and DRAM.
// assumes: master holds valid and packet until it sees ready.
`timescale 1ns/1ps
module qx_slave_model #(
	parameter int DLY = 0
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// request and answer
	input wire logic        valid,
	input qx_pkg::qx_req_t  pkt,
	output logic            ready,
	output logic            rspValid,
	output qx_pkg::qx_rsp_t rsp
);
	int waitQ;
	// answer only after the handshake edge; idle data toggles
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ready <= 1'b0;
			rspValid <= 1'b0;
			rsp <= '0;
			waitQ <= 0;
		end else begin
			rspValid <= ready;
			ready <= valid && !ready && waitQ >= DLY;
			waitQ <= (valid && !ready) ? waitQ + 1 : 0;
			if (ready)
				rsp <= '{rdata: {pkt.addr, ~pkt.addr}, err: 1'b0};
			else
				rsp <= qx_pkg::qx_rsp_t'(~rsp);
		end
	end
endmodule
